//--- pkg/exec_subset_params.svh
`ifndef EXEC_SUBSET_PARAMS_SVH
`define EXEC_SUBSET_PARAMS_SVH

// ************************************************************
// Field positions of the 16-bit instruction word.
// ************************************************************
`define OPC_MSB        15
`define OPC_LSB        10
`define DEST_BIT       8
`define ADDR_MSB       7
`define ADDR_LSB       0
`define LIT_MSB        7
`define LIT_LSB        0
`define JUMP_MSB       11
`define JUMP_LSB       0

// ************************************************************
// Reset values and timing counts.
// ************************************************************
`define ACC_RESET      8'h00
`define PC_RESET       12'h000
`define WDOG_RESET     16'h0000
`define CYC_ONE        2'h1
`define CYC_TWO        2'h2

`endif

//--- pkg/exec_subset_pkg.sv
package exec_subset_pkg;

	typedef enum logic [5:0] {
		OP_NOP      = 6'h00,
		OP_WDOG     = 6'h01,
		OP_INVERT   = 6'h02,
		OP_DEC      = 6'h03,
		OP_DEC_SKIP = 6'h04,
		OP_JUMP     = 6'h05,
		OP_HALT     = 6'h06,
		OP_INC      = 6'h07,
		OP_INC_SKIP = 6'h08,
		OP_OR_IMM   = 6'h09,
		OP_OR_MEM   = 6'h0a,
		OP_LOAD_ACC = 6'h0b,
		OP_LOAD_IMM = 6'h0c,
		OP_STORE    = 6'h0d
	} opcode_t;

	typedef enum logic [1:0] {
		ST_EXEC  = 2'b00,
		ST_FLUSH = 2'b01,
		ST_HALT  = 2'b10
	} exec_state_t;

	typedef struct packed {
		logic       carry;
		logic       digit_carry;
		logic       zero;
	} flags_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mem_wr_t;

endpackage : exec_subset_pkg

//--- rtl/exec_subset.sv
// Functional notes
// RULE_01 - The watchdog restart operation zeroes the watchdog count in one cycle, flags unchanged.
// RULE_02 - Destination bit 0 sends a result to the accumulator, 1 writes it back to memory.
// RULE_03 - The invert operation writes the one's complement of the operand and updates only zero.
// RULE_04 - The minus-one operation decrements the operand, updates zero, in one cycle.
// RULE_05 - Skip variants discard the next fetched instruction on a zero result, no flag change.
// RULE_06 - The jump operation loads its address into the counter, takes two cycles, no flags.
// RULE_07 - Halt stops the core until an internal or external wake request arrives.
// RULE_08 - The plus-one operation increments the operand into the chosen destination in one cycle.
// RULE_09 - The or-immediate operation ORs the accumulator with a literal and updates zero.
// RULE_10 - The or-memory operation ORs the accumulator with the operand and updates zero.
// RULE_11 - The load accumulator operation copies the operand to the accumulator, no flags.
// RULE_12 - The load immediate operation places the literal in the accumulator, no flags.
// RULE_13 - The store operation writes the accumulator to memory, accumulator and flags kept.
// RULE_14 - The core keeps carry, digit carry and zero flags.
// RULE_15 - An updated zero flag is set when the eight-bit result is zero, else cleared.
// RULE_16 - The no-operation takes one cycle and only advances the program counter.
`timescale 1ns/1ps
`default_nettype none
`include "exec_subset_params.svh"

module exec_subset
	import exec_subset_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// Instruction fetch.
	input  wire logic [15:0] instr,
	input  wire logic        instr_valid,
	// Data memory.
	input  wire logic [7:0]  mem_rdata,
	output logic [7:0]       mem_raddr,
	output mem_wr_t          mem_wr,
	// Wake-up requests.
	input  wire logic        wake_internal,
	input  wire logic        wake_external,
	// Core state.
	output logic [11:0]      pc,
	output logic [7:0]       acc,
	output flags_t           flags,
	output logic [15:0]      watchdog_count,
	output logic             core_halted,
	output logic             fetch_discard,
	output logic             instr_ready
);

	// ************************************************************
	// Helper functions.
	// ************************************************************
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00); // RULE_15
	endfunction : is_zero

	function automatic logic [11:0] pc_inc(input logic [11:0] p);
		pc_inc = p + 12'h001;
	endfunction : pc_inc

	function automatic logic [7:0] addr_field(input logic [15:0] w);
		addr_field = w[`ADDR_MSB:`ADDR_LSB];
	endfunction : addr_field

	function automatic logic [11:0] jump_field(input logic [15:0] w);
		jump_field = w[`JUMP_MSB:`JUMP_LSB];
	endfunction : jump_field

	function automatic logic is_skip(input opcode_t o);
		is_skip = (o == OP_DEC_SKIP) || (o == OP_INC_SKIP);
	endfunction : is_skip

	// ************************************************************
	// Decode.
	// ************************************************************
	exec_state_t state_ff;
	exec_state_t nxt_state;
	logic [11:0] pc_ff;
	logic [7:0]  acc_ff;
	flags_t      flags_ff;
	logic [15:0] wdog_ff;
	mem_wr_t     mem_wr_ff;

	opcode_t     op;
	logic        dest_mem;
	logic [7:0]  operand;
	logic [7:0]  literal;
	logic [7:0]  result;
	logic        writes_result;
	logic        sets_zero;
	logic        take;
	logic        wake;
	logic        word_in;
	logic        skip_hit;

	assign op       = opcode_t'(instr[`OPC_MSB:`OPC_LSB]);
	assign dest_mem = instr[`DEST_BIT];
	assign operand  = mem_rdata;
	assign literal  = instr[`LIT_MSB:`LIT_LSB];
	assign wake     = wake_internal | wake_external; // RULE_07
	assign word_in  = clk_en & instr_valid;
	assign take     = word_in & (state_ff == ST_EXEC);
	assign skip_hit = is_skip(op) & is_zero(result); // RULE_05

	// ************************************************************
	// Result selection.
	// ************************************************************
	// Memory is read combinationally, so the operand belongs to the word now on the bus.
	always_comb begin
		result        = 8'h00;
		writes_result = 1'b0;
		sets_zero     = 1'b0;
		case (op)
			OP_INVERT: begin
				result        = ~operand; // RULE_03
				writes_result = 1'b1;
				sets_zero     = 1'b1;
			end
			OP_DEC: begin
				result        = operand - 8'h01; // RULE_04
				writes_result = 1'b1;
				sets_zero     = 1'b1;
			end
			OP_DEC_SKIP: begin
				result        = operand - 8'h01; // RULE_05
				writes_result = 1'b1;
			end
			OP_INC: begin
				result        = operand + 8'h01; // RULE_08
				writes_result = 1'b1;
				sets_zero     = 1'b1;
			end
			OP_INC_SKIP: begin
				result        = operand + 8'h01; // RULE_05
				writes_result = 1'b1;
			end
			OP_OR_MEM: begin
				result        = acc_ff | operand; // RULE_10
				writes_result = 1'b1;
				sets_zero     = 1'b1;
			end
			OP_OR_IMM: begin
				result    = acc_ff | literal; // RULE_09
				sets_zero = 1'b1;
			end
			OP_LOAD_ACC: begin
				result = operand; // RULE_11
			end
			OP_LOAD_IMM: begin
				result = literal; // RULE_12
			end
			default: begin
				result        = 8'h00;
				writes_result = 1'b0;
				sets_zero     = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Sequencing.
	// ************************************************************
	// A jump or a zero-result skip spends one extra cycle consuming the word already fetched.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_EXEC: begin
				if (take) begin
					case (op)
						OP_JUMP:     nxt_state = ST_FLUSH; // RULE_06
						OP_HALT:     nxt_state = ST_HALT; // RULE_07
						default: begin
							if (skip_hit) begin
								nxt_state = ST_FLUSH; // RULE_05
							end
						end
					endcase
				end
			end
			ST_FLUSH: begin
				if (word_in) begin
					nxt_state = ST_EXEC;
				end
			end
			ST_HALT: begin
				if (wake) begin
					nxt_state = ST_EXEC; // RULE_07
				end
			end
			default: nxt_state = ST_EXEC;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_EXEC;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// Program counter.
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_ff <= `PC_RESET;
		end else if (take) begin
			if (op == OP_JUMP) begin
				pc_ff <= jump_field(instr); // RULE_06
			end else if (op != OP_HALT) begin
				pc_ff <= pc_inc(pc_ff); // RULE_16
			end
		end else if (word_in && state_ff == ST_FLUSH) begin
			pc_ff <= pc_inc(pc_ff); // RULE_05
		end else if (clk_en && state_ff == ST_HALT && wake) begin
			// A halted core keeps the counter on the halt word until it wakes.
			pc_ff <= pc_inc(pc_ff); // RULE_07
		end
	end

	// ************************************************************
	// Accumulator.
	// ************************************************************
	// Literal and load operations always land here; the others follow the destination bit.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_ff <= `ACC_RESET;
		end else if (take) begin
			case (op)
				OP_OR_IMM,
				OP_LOAD_ACC,
				OP_LOAD_IMM: acc_ff <= result;
				default: begin
					if (writes_result && !dest_mem) begin
						acc_ff <= result; // RULE_02
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Status flags.
	// ************************************************************
	// Carry and digit carry are kept for the rest of the instruction set and stay put here.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_ff <= '0; // RULE_14
		end else if (take && sets_zero) begin
			flags_ff.zero <= is_zero(result); // RULE_15
		end
	end

	// ************************************************************
	// Data memory write port.
	// ************************************************************
	// The write lands one cycle after execute, so a read of the same address in the very
	// next cycle still sees the old value.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_wr_ff <= '0;
		end else if (clk_en) begin
			mem_wr_ff.we <= 1'b0;
			if (take && op == OP_STORE) begin
				mem_wr_ff.we    <= 1'b1; // RULE_13
				mem_wr_ff.addr  <= addr_field(instr);
				mem_wr_ff.wdata <= acc_ff;
			end else if (take && writes_result && dest_mem) begin
				mem_wr_ff.we    <= 1'b1; // RULE_02
				mem_wr_ff.addr  <= addr_field(instr);
				mem_wr_ff.wdata <= result;
			end
		end
	end

	// ************************************************************
	// Watchdog restart.
	// ************************************************************
	// The count runs free on every enabled cycle so that a restart can be seen outside.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wdog_ff <= `WDOG_RESET;
		end else if (take && op == OP_WDOG) begin
			wdog_ff <= `WDOG_RESET; // RULE_01
		end else if (clk_en) begin
			wdog_ff <= wdog_ff + 16'h0001;
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************
	// Handshake outputs are decoded from state, instr_ready also gated by clk_en; mem_raddr comes from instr, other data outputs straight from registers.
	assign mem_raddr      = addr_field(instr);
	assign mem_wr         = mem_wr_ff;
	assign pc             = pc_ff;
	assign acc            = acc_ff;
	assign flags          = flags_ff;
	assign watchdog_count = wdog_ff;
	assign core_halted    = (state_ff == ST_HALT); // RULE_07
	assign fetch_discard  = (state_ff == ST_FLUSH);
	assign instr_ready    = clk_en & (state_ff != ST_HALT);

endmodule : exec_subset

`default_nettype wire

//--- test/data_store.sv
`timescale 1ns/1ps
`default_nettype none
module data_store
	import exec_subset_pkg::*;
(
	// Data memory port.
	input  wire logic       clk,
	input  wire logic [7:0] raddr,
	input  wire mem_wr_t    wr,
	output logic [7:0]      rdata
);
	logic [7:0] mem [256];
	assign rdata = mem[raddr];
	always @(posedge clk) begin
		if (wr.we)
			mem[wr.addr] <= wr.wdata;
	end
endmodule : data_store
`default_nettype wire

//--- test/exec_subset_props.sv
`timescale 1ns/1ps
`default_nettype none
module exec_subset_props
	import exec_subset_pkg::*;
(
	// Clock and fetch.
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic [15:0] instr,
	input wire logic        instr_valid,
	// Memory and wake.
	input wire logic [7:0]  mem_rdata,
	input wire logic [7:0]  mem_raddr,
	input wire mem_wr_t     mem_wr,
	input wire logic        wake_internal,
	input wire logic        wake_external,
	// Core state.
	input wire logic [11:0] pc,
	input wire logic [7:0]  acc,
	input wire flags_t      flags,
	input wire logic [15:0] watchdog_count,
	input wire logic        core_halted,
	input wire logic        fetch_discard,
	input wire logic        instr_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic       tk = clk_en && instr_valid && !core_halted && !fetch_discard;
	wire logic [5:0] op = instr[15:10];
	wdog_clear_a: assert property (tk && op == OP_WDOG |=> watchdog_count == 16'h0000
		&& $stable(flags)) else $error("watchdog restart wrong");
	inv_acc_a: assert property (tk && op == OP_INVERT && !instr[8] |=> acc == ~$past(mem_rdata)
		&& flags.zero == ($past(mem_rdata) == 8'hff)) else $error("invert wrong");
	dec_acc_a: assert property (tk && op == OP_DEC && !instr[8] |=>
		acc == $past(mem_rdata) - 8'h01) else $error("decrement wrong");
	inc_mem_a: assert property (tk && op == OP_INC && instr[8] |=> mem_wr.we && $stable(acc)
		&& mem_wr.wdata == $past(mem_rdata) + 8'h01) else $error("increment writeback wrong");
	skip_zero_a: assert property (tk && op == OP_INC_SKIP && mem_rdata == 8'hff |=>
		fetch_discard && $stable(flags)) else $error("skip missing");
	jump_pc_a: assert property (tk && op == OP_JUMP |=> pc == $past(instr[11:0]) &&
		fetch_discard ##1 (!fetch_discard || !$past(clk_en && instr_valid)))
		else $error("jump wrong");
	or_imm_a: assert property (tk && op == OP_OR_IMM |=> acc == ($past(acc) | $past(instr[7:0]))
		&& flags.zero == (acc == 8'h00)) else $error("or literal wrong");
	load_acc_a: assert property (tk && op == OP_LOAD_ACC |=> acc == $past(mem_rdata)
		&& $stable(flags)) else $error("load wrong");
	store_a: assert property (tk && op == OP_STORE |=> mem_wr.we && $stable(acc) &&
		mem_wr.addr == $past(instr[7:0]) && mem_wr.wdata == $past(acc)) else $error("store wrong");
	halt_a: assert property (tk && op == OP_HALT |=> core_halted && !instr_ready)
		else $error("halt wrong");
	nop_a: assert property (tk && op == OP_NOP |=> pc == $past(pc) + 12'h001 && $stable(acc))
		else $error("nop wrong");
	or_mem_a: assert property (tk && op == OP_OR_MEM && !instr[8] |=>
		acc == ($past(acc) | $past(mem_rdata)) && flags.zero == (acc == 8'h00))
		else $error("or memory wrong");
	load_imm_a: assert property (tk && op == OP_LOAD_IMM |=> acc == $past(instr[7:0])
		&& $stable(flags)) else $error("load literal wrong");
	frozen_state_a: assert property (!clk_en |=> $stable(flags) && $stable(pc)
		&& $stable(acc)) else $error("frozen state changed");
endmodule : exec_subset_props
bind exec_subset exec_subset_props exec_subset_props_i (.clk, .reset_n, .clk_en, .instr,
	.instr_valid, .mem_rdata, .mem_raddr, .mem_wr, .wake_internal, .wake_external, .pc, .acc,
	.flags, .watchdog_count, .core_halted, .fetch_discard, .instr_ready);
`default_nettype wire

//--- test/test_exec_subset.sv
`timescale 1ns/1ps
`default_nettype none
module test_exec_subset
	import exec_subset_pkg::*;
;
	logic        clk, reset_n, clk_en, instr_valid, wake_internal, wake_external;
	logic        core_halted, fetch_discard, instr_ready;
	logic [15:0] instr, watchdog_count;
	logic [7:0]  mem_rdata, mem_raddr, acc;
	logic [11:0] pc;
	mem_wr_t     mem_wr;
	flags_t      flags;
	opcode_t     o;
	int          errors, checks, cyc, seed, pc_m, acc_m, z_m, wd_s;
	int          mem_q[256];
	logic [15:0] dir_q [9] = '{16'h3000, 16'h2400, 16'h24ff, 16'h3410, 16'h2c10, 16'h0400,
		16'h0000, 16'h17ff, 16'h0910};
	exec_subset exec_subset_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .instr(instr),
		.instr_valid(instr_valid), .mem_rdata(mem_rdata), .mem_raddr(mem_raddr),
		.mem_wr(mem_wr), .wake_internal(wake_internal), .wake_external(wake_external),
		.pc(pc), .acc(acc), .flags(flags), .watchdog_count(watchdog_count),
		.core_halted(core_halted), .fetch_discard(fetch_discard), .instr_ready(instr_ready));
	data_store mem_i (.clk(clk), .raddr(mem_raddr), .wr(mem_wr), .rdata(mem_rdata));
	task automatic check(input logic [15:0] g, e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check
	task automatic final_report();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic poke(input int a, v);
		mem_q[a] = v;
		mem_i.mem[a] = v[7:0];
	endtask : poke
	task automatic exec(input opcode_t op, input logic [9:0] r);
		int res;
		bit dop, wr, skp;
		dop = op inside {OP_INVERT, OP_DEC, OP_DEC_SKIP, OP_INC, OP_INC_SKIP, OP_OR_MEM};
		case (op)
			OP_INVERT: res = ~mem_q[r[7:0]];
			OP_DEC, OP_DEC_SKIP: res = mem_q[r[7:0]] - 1;
			OP_INC, OP_INC_SKIP: res = mem_q[r[7:0]] + 1;
			OP_OR_MEM: res = acc_m | mem_q[r[7:0]];
			OP_OR_IMM: res = acc_m | r[7:0];
			OP_LOAD_ACC: res = mem_q[r[7:0]];
			OP_LOAD_IMM: res = r[7:0];
			default: res = acc_m;
		endcase
		res = res & 255;
		wr = (dop && r[8]) || op == OP_STORE;
		skp = (op inside {OP_DEC_SKIP, OP_INC_SKIP} && res == 0) || op == OP_JUMP;
		if (op inside {OP_INVERT, OP_DEC, OP_INC, OP_OR_MEM, OP_OR_IMM})
			z_m = (res == 0);
		if ((dop && !r[8]) || op inside {OP_OR_IMM, OP_LOAD_ACC, OP_LOAD_IMM})
			acc_m = res;
		if (wr)
			mem_q[r[7:0]] = res;
		pc_m = (op == OP_JUMP) ? {op[1:0], r} : (op == OP_HALT) ? pc_m : pc_m + 1;
		instr = {op, r};
		@(negedge clk);
		check(acc, acc_m[7:0]);
		check(pc, pc_m[11:0]);
		check(flags, {2'b00, z_m[0]});
		check(mem_wr.we, wr);
		if (wr)
			check({mem_wr.addr, mem_wr.wdata}, {r[7:0], res[7:0]});
		check(fetch_discard, skp);
		check(instr_ready, op != OP_HALT);
		if (op == OP_WDOG)
			check(watchdog_count, 16'h0000);
		if (skp || wr) begin
			instr = skp ? {OP_LOAD_IMM, 10'h05a} : {OP_NOP, 10'h000};
			@(negedge clk);
			pc_m++;
			check(pc, pc_m[11:0]);
			check(acc, acc_m[7:0]);
		end
	endtask : exec
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		{reset_n, wake_internal, wake_external} = 3'b000;
		{clk_en, instr_valid} = 2'b11;
		instr = 16'h0000;
		seed = 32'h0c62761f;
		for (int i = 0; i < 256; i++)
			poke(i, $random(seed) & 255);
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		foreach (dir_q[i])
			exec(opcode_t'(dir_q[i][15:10]), dir_q[i][9:0]);
		poke(32, 255);
		exec(OP_INC_SKIP, 10'h020);
		poke(33, 1);
		exec(OP_DEC_SKIP, 10'h121);
		$display("directed test done");
		repeat (300) begin
			{clk_en, instr_valid} = 2'($unsigned($random(seed)) % 3);
			instr = 16'($random(seed));
			wd_s = watchdog_count + clk_en;
			@(negedge clk);
			check(pc, pc_m[11:0]);
			check(acc, acc_m[7:0]);
			check(watchdog_count, wd_s[15:0]);
			{clk_en, instr_valid} = 2'b11;
			o = opcode_t'(6'($unsigned($random(seed)) % 14));
			exec(o == OP_HALT ? OP_NOP : o, 10'($random(seed)));
		end
		$display("random test done");
		for (int i = 1; i < 3; i++) begin
			exec(OP_HALT, 10'h000);
			instr = {OP_LOAD_IMM, 10'h0aa};
			repeat (3) @(negedge clk);
			check(acc, acc_m[7:0]);
			{wake_external, wake_internal} = i[1:0];
			@(negedge clk);
			{wake_external, wake_internal} = 2'b00;
			pc_m++;
			check(core_halted, 1'b0);
			check(pc, pc_m[11:0]);
		end
		$display("halt test done");
		final_report();
	end
endmodule : test_exec_subset
`default_nettype wire
